// [rtl/aifl_pkg.sv]
package aifl_pkg;
   // serial command byte: [7:6] device address, [5:2] register address, [1:0] command type
   localparam logic [1:0] DEV_ADDR = 2'h1; // arbitrary value
   localparam logic [1:0] CMD_FAST = 2'h0;
   localparam logic [1:0] CMD_SREAD = 2'h1;
   localparam logic [1:0] CMD_IWRITE = 2'h2;
   localparam logic [1:0] CMD_IREAD = 2'h3;
   localparam logic [3:0] ADDR_RESULT = 4'h0;
   localparam logic [3:0] ADDR_IRQ = 4'h5;
   localparam logic [3:0] ADDR_LOCK = 4'hD;
   localparam logic [3:0] FAST_START = 4'hA;
   localparam logic [7:0] UNLOCK_KEY = 8'hA5;
   localparam logic [7:0] LOCK_RESET = 8'hA5;
   // edge counts inside a frame
   localparam logic [4:0] ADDR_EDGES = 5'h02;
   localparam logic [4:0] BYTE_EDGES = 5'h08;
   localparam logic [4:0] FIRST_DATA_FALL = 5'h09;
   localparam logic [4:0] TWO_BYTE_EDGES = 5'h10;
   // timing in digital master clock periods
   localparam logic [15:0] DR_EARLY_TICKS = 16'h0010;
   localparam logic [15:0] START_PULSE_TICKS = 16'h0010;
   // status byte: [7:6] address echo, [5:3] fill, [2] data ready, [1] checksum, [0] power-on
   localparam logic [2:0] STATUS_FILL = 3'h7;
   // interrupt register: [6] data ready, [5] checksum, [4] power-on, [3:2] pin mode, [0] start pulse enable
   localparam int IRQ_MODE_LO = 2;
   localparam int IRQ_MODE_HI = 3;
   localparam int IRQ_STP_EN = 0;
   localparam logic [1:0] PIN_MODE_RESET = 2'h0;
   localparam logic STP_EN_RESET = 1'b1;
   // synchroniser lanes and their idle levels: cs_n, sck, sdi, avdd ok, dvdd ok
   localparam int SYNC_W = 5;
   localparam logic [4:0] SYNC_RESET = 5'h10;
   typedef enum logic [1:0] {AIFL_IDLE, AIFL_CMD, AIFL_DATA, AIFL_SKIP} aifl_state_t;
endpackage

// [rtl/aifl_sync.sv]
`timescale 1ns/10ps
module aifl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic sysClk,
   input wire logic reset,
   // asynchronous in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } aifl_sync_t;

   aifl_sync_t r_reg, r_next;

   always_comb begin
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge sysClk) begin
      if (reset) begin
         r_reg <= '{s1: RST, s2: RST};
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.s2;
endmodule

// [rtl/aifl_flags.sv]
`timescale 1ns/10ps
// Function
// - snapshot status flags once device address matches; shift as status byte each command
// - clear reported status-byte flags at last falling sck of status byte
// - interrupt register at address 0x5, snapshot at start of its read
// - clear interrupt register flags to one at last falling sck of its read
// - pin mode upper bit 0: every source may pull the pin low
// - pin mode upper bit 1: only power-on and checksum sources pull low
// - start pulse pin indication self-releases after start pulse duration
// - data-ready pin released by first data-byte falling sck of a result read, or 16 ticks early in continuous mode only
// - power-on pin released by cs falling edge while both supplies are good
// - checksum pin released by lock write 0xA5 or start fast command
// - data-ready event raised with master clock at each end of conversion
// - status byte data-ready bit 0 while pending, 1 after, 0 on new event
// - data-ready event between interrupt register reads makes later read 0
// - interrupt pin falls at once on data ready when mode allows
// - start pulse only on pin, gated by enable bit, default enabled
// - first status byte after power-up shows power-on bit low
// - checksum error outranks all sources but power-on, and the bitstream
module aifl_flags (
   // clock and reset
   input wire logic sysClk,
   input wire logic reset,
   // serial pins
   input wire logic csN,
   input wire logic sck,
   input wire logic sdi,
   output logic sdoOut,
   output logic sdoOe,
   // supply monitors
   input wire logic avddOk,
   input wire logic dvddOk,
   // converter core, same clock
   input wire logic dmclkTick,
   input wire logic drEvent,
   input wire logic convStartEvent,
   input wire logic crcErrEvent,
   input wire logic continuousMode,
   input wire logic [15:0] convLengthTicks,
   input wire logic modulatorBit,
   // interrupt pin and lock state
   output logic irqOut,
   output logic irqOe,
   output logic registerMapLocked
);
   typedef struct packed {
      aifl_pkg::aifl_state_t st;
      logic sckPrev;
      logic csPrev;
      logic [4:0] riseCnt;
      logic [4:0] fallCnt;
      logic [7:0] shiftIn;
      logic [7:0] cmd;
      logic [7:0] outByte;
      logic snapTaken;
      logic [2:0] statusSnap;
      logic [2:0] irqSnap;
      logic drStatus;
      logic crcStatus;
      logic porStatus;
      logic drIrq;
      logic crcIrq;
      logic porIrq;
      logic drPin;
      logic crcPin;
      logic porPin;
      logic stpPin;
      logic drArm;
      logic [15:0] stpCount;
      logic [15:0] drCount;
      logic [1:0] pinMode;
      logic stpEnable;
      logic [7:0] lockKey;
      logic sdoOut;
      logic sdoOe;
      logic irqOut;
      logic irqOe;
      logic locked;
   } aifl_regs_t;

   function automatic logic aifl_is_read(input logic [1:0] t);
      return (t == aifl_pkg::CMD_SREAD) || (t == aifl_pkg::CMD_IREAD);
   endfunction

   aifl_regs_t r_reg, r_next;
   logic [4:0] syncQ;
   logic csS, sckS, sdiS, suppliesOk;
   logic sckRise, sckFall, csFall;
   logic statusClr, irqClr, unlockWr, fastStart, resultFall, porCond, crcSet;

   aifl_sync #(.W(aifl_pkg::SYNC_W), .RST(aifl_pkg::SYNC_RESET)) u_sync (
      .sysClk(sysClk),
      .reset(reset),
      .d({csN, sck, sdi, avddOk, dvddOk}),
      .q(syncQ)
   );
   assign {csS, sckS, sdiS} = syncQ[4:2];
   assign suppliesOk = syncQ[1] & syncQ[0];

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      r_next = r_reg;
      sckRise = sckS & ~r_reg.sckPrev & ~csS;
      sckFall = ~sckS & r_reg.sckPrev & ~csS;
      csFall = ~csS & r_reg.csPrev;
      statusClr = 1'b0;
      irqClr = 1'b0;
      unlockWr = 1'b0;
      fastStart = 1'b0;
      resultFall = 1'b0;
      porCond = ~suppliesOk;
      crcSet = crcErrEvent & r_reg.locked;
      r_next.sckPrev = sckS;
      r_next.csPrev = csS;

      // serial frame
      if (csS) begin
         r_next.st = aifl_pkg::AIFL_IDLE;
         r_next.sdoOe = 1'b0;
      end else if (csFall) begin
         r_next.st = aifl_pkg::AIFL_CMD;
         r_next.riseCnt = '0;
         r_next.fallCnt = '0;
         r_next.snapTaken = 1'b0;
         // stale command must not clear flags in a refused frame
         r_next.cmd = '0;
         r_next.outByte = {aifl_pkg::DEV_ADDR, 6'h3F};
         r_next.sdoOe = 1'b1;
      end else if (r_reg.st != aifl_pkg::AIFL_IDLE) begin
         if (sckRise) begin
            r_next.shiftIn = {r_reg.shiftIn[6:0], sdiS};
            r_next.riseCnt = r_reg.riseCnt + 5'h01;
            if (r_next.riseCnt == aifl_pkg::ADDR_EDGES) begin
               if (r_next.shiftIn[1:0] == aifl_pkg::DEV_ADDR) begin
                  // snapshot all three together so the byte is coherent
                  r_next.snapTaken = 1'b1;
                  r_next.statusSnap = {r_reg.drStatus, r_reg.crcStatus, r_reg.porStatus};
                  r_next.outByte[5:0] = {aifl_pkg::STATUS_FILL, ~r_reg.drStatus, ~r_reg.crcStatus,
                     ~r_reg.porStatus};
               end else begin
                  r_next.st = aifl_pkg::AIFL_SKIP;
                  r_next.sdoOe = 1'b0;
               end
            end else if (r_next.riseCnt == aifl_pkg::BYTE_EDGES && r_reg.st == aifl_pkg::AIFL_CMD) begin
               r_next.cmd = r_next.shiftIn;
               if (r_next.shiftIn[1:0] == aifl_pkg::CMD_FAST) begin
                  fastStart = (r_next.shiftIn[5:2] == aifl_pkg::FAST_START);
                  r_next.st = aifl_pkg::AIFL_SKIP;
               end else begin
                  r_next.st = aifl_pkg::AIFL_DATA;
               end
            end else if (r_next.riseCnt == aifl_pkg::TWO_BYTE_EDGES && r_reg.st == aifl_pkg::AIFL_DATA) begin
               if (r_reg.cmd[1:0] == aifl_pkg::CMD_IWRITE) begin
                  if (r_reg.cmd[5:2] == aifl_pkg::ADDR_IRQ) begin
                     r_next.pinMode = r_next.shiftIn[aifl_pkg::IRQ_MODE_HI:aifl_pkg::IRQ_MODE_LO];
                     r_next.stpEnable = r_next.shiftIn[aifl_pkg::IRQ_STP_EN];
                  end else if (r_reg.cmd[5:2] == aifl_pkg::ADDR_LOCK) begin
                     r_next.lockKey = r_next.shiftIn;
                     unlockWr = (r_next.shiftIn == aifl_pkg::UNLOCK_KEY);
                  end
               end
               r_next.st = aifl_pkg::AIFL_SKIP;
            end
         end
         if (sckFall) begin
            r_next.fallCnt = r_reg.fallCnt + 5'h01;
            if (r_next.fallCnt == aifl_pkg::BYTE_EDGES) begin
               statusClr = r_reg.snapTaken;
               r_next.outByte = '0;
               if (r_reg.st == aifl_pkg::AIFL_DATA && aifl_is_read(r_reg.cmd[1:0])
                   && r_reg.cmd[5:2] == aifl_pkg::ADDR_IRQ) begin
                  r_next.irqSnap = {r_reg.drIrq, r_reg.crcIrq, r_reg.porIrq};
                  r_next.outByte = {1'b0, ~r_reg.drIrq, ~r_reg.crcIrq, ~r_reg.porIrq,
                     r_reg.pinMode, 1'b0, r_reg.stpEnable};
               end
            end else if (r_next.fallCnt == aifl_pkg::FIRST_DATA_FALL && r_reg.st != aifl_pkg::AIFL_SKIP
                         && aifl_is_read(r_reg.cmd[1:0]) && r_reg.cmd[5:2] == aifl_pkg::ADDR_RESULT) begin
               resultFall = 1'b1;
            end else if (r_next.fallCnt == aifl_pkg::TWO_BYTE_EDGES && aifl_is_read(r_reg.cmd[1:0])
                         && r_reg.cmd[5:2] == aifl_pkg::ADDR_IRQ) begin
               irqClr = 1'b1;
               r_next.st = aifl_pkg::AIFL_SKIP;
            end
         end
      end
      r_next.sdoOut = r_next.outByte[~r_next.fallCnt[2:0]];
      r_next.locked = (r_next.lockKey != aifl_pkg::UNLOCK_KEY);

      // flags: a set in the same cycle as a clear wins
      r_next.drStatus = drEvent | (r_reg.drStatus & ~(statusClr & r_reg.statusSnap[2]));
      r_next.crcStatus = crcSet | (r_reg.crcStatus & ~(statusClr & r_reg.statusSnap[1]));
      r_next.porStatus = porCond | (r_reg.porStatus & ~(statusClr & r_reg.statusSnap[0]));
      r_next.drIrq = drEvent | (r_reg.drIrq & ~(irqClr & r_reg.irqSnap[2]));
      r_next.crcIrq = crcSet | (r_reg.crcIrq & ~(irqClr & r_reg.irqSnap[1]));
      r_next.porIrq = porCond | (r_reg.porIrq & ~(irqClr & r_reg.irqSnap[0]));

      // start pulse countdown in master clock ticks
      if (convStartEvent) begin
         r_next.stpPin = 1'b1;
         r_next.stpCount = aifl_pkg::START_PULSE_TICKS;
      end else if (r_reg.stpPin && dmclkTick) begin
         r_next.stpCount = r_reg.stpCount - 16'h0001;
         r_next.stpPin = (r_reg.stpCount != 16'h0001);
      end

      // data ready pin with early automatic release
      if (drEvent) begin
         r_next.drPin = 1'b1;
         r_next.drArm = (convLengthTicks > aifl_pkg::DR_EARLY_TICKS);
         r_next.drCount = convLengthTicks - aifl_pkg::DR_EARLY_TICKS;
      end else begin
         if (r_reg.drArm && dmclkTick) begin
            r_next.drCount = r_reg.drCount - 16'h0001;
            if (r_reg.drCount == 16'h0001) begin
               r_next.drArm = 1'b0;
               if (continuousMode) begin
                  r_next.drPin = 1'b0;
               end
            end
         end
         if (resultFall) begin
            r_next.drPin = 1'b0;
         end
      end

      r_next.porPin = porCond | (r_reg.porPin & ~(csFall & suppliesOk));
      r_next.crcPin = crcSet | (r_reg.crcPin & ~(unlockWr | fastStart));

      // pin: power-on and checksum force low over everything, bitstream included
      if (r_next.porPin || r_next.crcPin) begin
         r_next.irqOut = 1'b0;
      end else if (r_next.pinMode[1]) begin
         r_next.irqOut = modulatorBit;
      end else begin
         r_next.irqOut = ~(r_next.drPin | (r_next.stpEnable & r_next.stpPin));
      end
      r_next.irqOe = r_next.pinMode[0] | ~r_next.irqOut;
   end

   always_ff @(posedge sysClk) begin
      if (reset) begin
         r_reg <= '0;
         r_reg.st <= aifl_pkg::AIFL_IDLE;
         r_reg.csPrev <= 1'b1;
         // power-up counts as a power-on event on all three paths
         r_reg.porStatus <= 1'b1;
         r_reg.porIrq <= 1'b1;
         r_reg.porPin <= 1'b1;
         r_reg.pinMode <= aifl_pkg::PIN_MODE_RESET;
         r_reg.stpEnable <= aifl_pkg::STP_EN_RESET;
         r_reg.lockKey <= aifl_pkg::LOCK_RESET;
         r_reg.irqOe <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sdoOut = r_reg.sdoOut;
   assign sdoOe = r_reg.sdoOe;
   assign irqOut = r_reg.irqOut;
   assign irqOe = r_reg.irqOe;
   assign registerMapLocked = r_reg.locked;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sysClk); endclocking
   default disable iff (reset);

   sequence s_statusByteEnd;
      statusClr && r_reg.statusSnap[2] && !drEvent;
   endsequence
   sequence s_drCleared;
      !r_reg.drStatus;
   endsequence

   property p_statusClear;
      s_statusByteEnd |=> s_drCleared;
   endproperty
   a_statusClear: assert property (p_statusClear) else $error("status data-ready not cleared");

   property p_drSet;
      drEvent |=> r_reg.drStatus && r_reg.drIrq && r_reg.drPin;
   endproperty
   a_drSet: assert property (p_drSet) else $error("data-ready event lost");

   property p_irqClear;
      irqClr && r_reg.irqSnap[2] && !drEvent |=> !r_reg.drIrq;
   endproperty
   a_irqClear: assert property (p_irqClear) else $error("interrupt register not cleared");

   property p_drPinFall;
      drEvent && !r_reg.pinMode[1] |=> !irqOut;
   endproperty
   a_drPinFall: assert property (p_drPinFall) else $error("pin did not fall on data ready");

   property p_crcPriority;
      r_reg.crcPin |-> !irqOut;
   endproperty
   a_crcPriority: assert property (p_crcPriority) else $error("checksum error not on pin");

   property p_modeUpper;
      r_reg.pinMode[1] && !r_reg.porPin && !r_reg.crcPin |-> irqOut == $past(modulatorBit);
   endproperty
   a_modeUpper: assert property (p_modeUpper) else $error("pin mode upper bit not honoured");

   property p_porRelease;
      csFall && suppliesOk |=> !r_reg.porPin;
   endproperty
   a_porRelease: assert property (p_porRelease) else $error("power-on pin not released");

   property p_crcRelease;
      (unlockWr || fastStart) && !crcSet |=> !r_reg.crcPin;
   endproperty
   a_crcRelease: assert property (p_crcRelease) else $error("checksum pin not released");

   property p_stpLoad;
      convStartEvent |=> r_reg.stpPin && r_reg.stpCount == aifl_pkg::START_PULSE_TICKS;
   endproperty
   a_stpLoad: assert property (p_stpLoad) else $error("start pulse not loaded");

   property p_stpGate;
      !r_reg.stpEnable && !r_reg.pinMode[1] && !r_reg.porPin && !r_reg.crcPin && !r_reg.drPin |-> irqOut;
   endproperty
   a_stpGate: assert property (p_stpGate) else $error("disabled start pulse on pin");
endmodule

// [verification/aifl_host_model.sv]
`timescale 1ns/10ps
module aifl_host_model (
   // serial pins driven by the host
   output logic csN,
   output logic sck,
   output logic sdi,
   // device answers
   input wire logic sdoOut,
   input wire logic sdoOe,
   input wire logic irqOut,
   input wire logic irqOe,
   // resolved pin and notification count
   output logic irqPin,
   output int irqFalls
);
   logic lastSdo = 1'b0;
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
      irqFalls = 0;
   end
   // open-drain pin: pull-up wins whenever nobody drives
   assign irqPin = irqOe ? irqOut : 1'b1;
   always @(negedge irqPin) begin
      irqFalls++;
   end
   ////////////////////////////////////////////////////////////////////////
   // mode 0,0 frame, msb first, n bits taken from the top of tx
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      csN = 1'b0;
      #125;
      for (int i = 15; i > 15 - n; i--) begin
         sdi = tx[i];
         #62.5 sck = 1'b1;
         // a released line is not trusted to hold its last bit
         lastSdo = sdoOe ? sdoOut : ~lastSdo;
         rx[i] = lastSdo;
         #62.5 sck = 1'b0;
      end
      sdi = ~sdi;
      #62.5 csN = 1'b1;
      #125;
   endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
   // clock, reset and converter side
   logic sysClk = 1'b0;
   logic reset = 1'b1;
   logic avddOk = 1'b1;
   logic dvddOk = 1'b1;
   logic dmclkTick = 1'b0;
   logic drEvent = 1'b0;
   logic convStartEvent = 1'b0;
   logic crcErrEvent = 1'b0;
   logic continuousMode = 1'b0;
   logic [15:0] convLengthTicks = 16'h0028;
   logic modBit = 1'b1;
   logic [7:0] tickCnt = 8'h00;
   // pins
   logic csN, sck, sdi, sdoOut, sdoOe, irqOut, irqOe, irqPin, registerMapLocked;
   logic [15:0] rx;
   int irqFalls, f0, seed;
   int n_fail = 0;
   int compares = 0;

   always #4 sysClk = ~sysClk;
   // one master clock tick every four cycles
   always @(posedge sysClk) begin
      tickCnt <= tickCnt + 8'h01;
      dmclkTick <= (tickCnt[1:0] == 2'h3);
   end

   aifl_flags u_aifl_flags (.sysClk(sysClk), .reset(reset), .csN(csN), .sck(sck), .sdi(sdi),
      .sdoOut(sdoOut), .sdoOe(sdoOe), .avddOk(avddOk), .dvddOk(dvddOk), .dmclkTick(dmclkTick),
      .drEvent(drEvent), .convStartEvent(convStartEvent), .crcErrEvent(crcErrEvent),
      .continuousMode(continuousMode), .convLengthTicks(convLengthTicks), .modulatorBit(modBit),
      .irqOut(irqOut), .irqOe(irqOe), .registerMapLocked(registerMapLocked));
   aifl_host_model u_aifl_host_model (.csN(csN), .sck(sck), .sdi(sdi), .sdoOut(sdoOut),
      .sdoOe(sdoOe), .irqOut(irqOut), .irqOe(irqOe), .irqPin(irqPin), .irqFalls(irqFalls));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] cmd(input logic [3:0] a, input logic [1:0] t);
      return {aifl_pkg::DEV_ADDR, a, t};
   endfunction
   function automatic logic [7:0] stat(input logic dr, input logic crc, input logic por);
      return {aifl_pkg::DEV_ADDR, aifl_pkg::STATUS_FILL, ~dr, ~crc, ~por};
   endfunction
   function automatic logic [7:0] irqb(input logic dr, crc, por, input logic [1:0] m, input logic s);
      return {1'b0, ~dr, ~crc, ~por, m, 1'b0, s};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pin(input logic exp);
      chk({7'h00, irqPin}, {7'h00, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sysClk);
      #1;
   endtask
   // k = {checksum, start, data ready}, one-cycle pulses
   task automatic pulse(input logic [2:0] k);
      {crcErrEvent, convStartEvent, drEvent} = k;
      cyc(1);
      {crcErrEvent, convStartEvent, drEvent} = 3'h0;
      cyc(2);
   endtask
   task automatic frame(input logic [7:0] c, input logic [7:0] d, input int n);
      u_aifl_host_model.xfer({c, d}, n, rx);
      cyc(4);
   endtask
   task automatic rd_irq(input logic [7:0] es, input logic [7:0] ei);
      logic [1:0] t;
      t = ($urandom_range(1, 0) != 0) ? aifl_pkg::CMD_IREAD : aifl_pkg::CMD_SREAD;
      frame(cmd(aifl_pkg::ADDR_IRQ, t), 8'h00, 16);
      chk(rx[15:8], es);
      chk(rx[7:0], ei);
   endtask
   task automatic stop_test;
      $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge sysClk);
      n_fail++;
      stop_test();
   end

   initial begin
      seed = $urandom(32'hf269);
      repeat (20) @(posedge sysClk);
      #1 reset = 1'b0;
      cyc(5);
      // power-on flags pending until the first frame
      pin(1'b0);
      rd_irq(stat(0, 0, 1), irqb(0, 0, 1, 2'h0, 1));
      pin(1'b1);
      rd_irq(stat(0, 0, 0), irqb(0, 0, 0, 2'h0, 1));
      $display("test por done");

      f0 = irqFalls;
      repeat ($urandom_range(3, 1)) begin
         pulse(3'h1);
         pin(1'b0);
         cyc($urandom_range(40, 1));
      end
      chk(8'(irqFalls - f0), 8'h01);
      rd_irq(stat(1, 0, 0), irqb(1, 0, 0, 2'h0, 1));
      pin(1'b0);
      pulse(3'h1);
      // foreign device address: output released, nothing snapped or cleared
      frame({2'h2, aifl_pkg::ADDR_IRQ, aifl_pkg::CMD_SREAD}, 8'h00, 16);
      chk(rx[15:8], 8'h55);
      rd_irq(stat(1, 0, 0), irqb(1, 0, 0, 2'h0, 1));
      rd_irq(stat(0, 0, 0), irqb(0, 0, 0, 2'h0, 1));
      frame(cmd(aifl_pkg::ADDR_RESULT, aifl_pkg::CMD_SREAD), 8'h00, 16);
      pin(1'b1);
      $display("test data ready done");

      pulse(3'h2);
      pin(1'b0);
      cyc(80);
      pin(1'b1);
      frame(cmd(aifl_pkg::ADDR_IRQ, aifl_pkg::CMD_IWRITE), 8'h00, 16);
      pulse(3'h2);
      pin(1'b1);
      rd_irq(stat(0, 0, 0), irqb(0, 0, 0, 2'h0, 0));
      $display("test start pulse done");

      // upper mode bit set, push-pull: pin shows a random bitstream level
      frame(cmd(aifl_pkg::ADDR_IRQ, aifl_pkg::CMD_IWRITE), 8'h0D, 16);
      modBit = 1'($urandom);
      pulse(3'h3);
      pin(modBit);
      modBit = 1'b1;
      rd_irq(stat(1, 0, 0), irqb(1, 0, 0, 2'h3, 1));
      frame(cmd(aifl_pkg::ADDR_RESULT, aifl_pkg::CMD_SREAD), 8'h00, 16);
      frame(cmd(aifl_pkg::ADDR_LOCK, aifl_pkg::CMD_IWRITE), 8'h00, 16);
      chk({7'h00, registerMapLocked}, 8'h01);
      pulse(3'h4);
      pin(1'b0);
      frame(cmd(aifl_pkg::FAST_START, aifl_pkg::CMD_FAST), 8'h00, 8);
      pin(1'b1);
      frame(cmd(aifl_pkg::ADDR_IRQ, aifl_pkg::CMD_IWRITE), 8'h01, 16);
      pulse(3'h4);
      pin(1'b0);
      rd_irq(stat(0, 1, 0), irqb(0, 1, 0, 2'h0, 1));
      pin(1'b0);
      frame(cmd(aifl_pkg::ADDR_LOCK, aifl_pkg::CMD_IWRITE), aifl_pkg::UNLOCK_KEY, 16);
      pin(1'b1);
      chk({7'h00, registerMapLocked}, 8'h00);
      $display("test checksum done");

      avddOk = 1'b0;
      cyc(10);
      pin(1'b0);
      frame(cmd(aifl_pkg::ADDR_IRQ, aifl_pkg::CMD_FAST), 8'h00, 8);
      pin(1'b0);
      avddOk = 1'b1;
      cyc(10);
      frame(cmd(aifl_pkg::ADDR_IRQ, aifl_pkg::CMD_FAST), 8'h00, 8);
      pin(1'b1);
      $display("test supply done");

      // no read: the pin must let go on its own before the next result
      continuousMode = 1'b1;
      pulse(3'h1);
      cyc(80);
      pin(1'b0);
      cyc(30);
      pin(1'b1);
      continuousMode = 1'b0;
      $display("test early release done");
      stop_test();
   end
endmodule
